// ==== bench/gpcv_port_share_chk.sv ====
// Purpose: Port-level checks for gpcv_port_share.
// Assumes: Two-flop pin sync; read data only in the cycle after the strobe.
// Notes: Pin-sync depth is fixed at two, so the converter pass-through uses $past depth 2.
`timescale 1ns/1ps
module gpcv_port_share_chk (
  // Clock, reset and register port
  input wire ref_clk, input wire rst, input wire [7:0] regAddr, input wire [7:0] regWrData,
  input wire regWrStb, input wire regRdStb, input wire [7:0] regRdData,
  // Port pins
  input wire [7:0] port0PinOe, input wire [7:0] port0PullEn, input wire [7:0] port1PinOut,
  input wire [7:0] port1PinOe, input wire [7:0] port1PullEn, input wire [7:0] port5PinIn,
  input wire [7:0] port5PinOe, input wire [7:0] port5PullEn,
  // Converter side
  input wire [2:0] convChannelIn, input wire convFeedbackClk, input wire convInputEnable,
  input wire [1:0] convChannelSel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rd_pull0; regRdStb && regAddr == 8'he0 |=> regRdData == 8'h04; endproperty
  a_rd_pull0: assert property (p_rd_pull0) else $error("pull-up 0 read wrong");
  property p_rd_wo; regRdStb && regAddr[7:4] == 4'he && regAddr != 8'he0 |=> regRdData == 8'h00; endproperty
  a_rd_wo: assert property (p_rd_wo) else $error("write-only read not zero");
  property p_rd_idle; !regRdStb |=> regRdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_wr_out; regWrStb && regAddr == 8'hd1 |=> port1PinOut == ($past(regWrData) & 8'h7f); endproperty
  a_wr_out: assert property (p_wr_out) else $error("port 1 latch not driven");
  property p_pull_in;
    regWrStb && regAddr == 8'he1 |=> port1PullEn == ($past(regWrData) & ~port1PinOe & 8'h7f);
  endproperty
  a_pull_in: assert property (p_pull_in) else $error("port 1 pull-up wrong");
  property p_p02; port0PinOe[2] == 1'b0 && port0PullEn[2] == 1'b0; endproperty
  a_p02: assert property (p_p02) else $error("input-only pin driven or pulled");
  property p_conv_pins; convInputEnable |-> port5PinOe[3:0] == 4'h0 && port5PullEn[3:0] == 4'h0; endproperty
  a_conv_pins: assert property (p_conv_pins) else $error("converter pins still digital");
  property p_conv_ch; convInputEnable |-> {convFeedbackClk, convChannelIn} == $past(port5PinIn[3:0], 2); endproperty
  a_conv_ch: assert property (p_conv_ch) else $error("converter inputs not passed");
  property p_conv_off; !convInputEnable |-> {convFeedbackClk, convChannelIn} == 4'h0; endproperty
  a_conv_off: assert property (p_conv_off) else $error("converter inputs leak");
  property p_ctrl; regWrStb && regAddr == 8'ha3 |=> {convChannelSel, convInputEnable} == $past(regWrData[2:0]); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control bits not stored");
  c_conv: cover property (convInputEnable && convChannelSel == 2'h3);
  c_rd0: cover property (regRdStb && regAddr == 8'he0);
  c_out: cover property (port5PinOe[5] && convInputEnable);
endmodule // gpcv_port_share_chk
bind gpcv_port_share gpcv_port_share_chk gpcv_port_share_chk_i (.*);

// ==== bench/testbench.sv ====
// Purpose: Register-port tests for gpcv_port_share.
// Assumes: Pins held stable long enough to pass the two-flop sync.
// Notes: External-reset option is left at its default.
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 0, rst = 1, regWrStb = 0, regRdStb = 0, convOutput = 0, convFeedbackClk, convInputEnable;
  logic [7:0] regAddr = 0, regWrData = 0, regRdData, port0PinIn = 0, port1PinIn = 0, port3PinIn = 0, port5PinIn = 0;
  logic [7:0] port0PinOut, port0PinOe, port0PullEn, port1PinOut, port1PinOe, port1PullEn, port3PinOut, port3PinOe;
  logic [7:0] port3PullEn, port5PinOut, port5PinOe, port5PullEn;
  logic [2:0] convChannelIn;
  logic [1:0] convChannelSel;
  logic [7:0] zr [8] = '{8'he1, 8'he3, 8'he5, 8'hd0, 8'hd1, 8'hd3, 8'hd5, 8'h7f};
  int num_errors = 0, check_count = 0, cycles = 0;
  gpcv_port_share gpcv_port_share_i (.*);
  always #4 ref_clk = ~ref_clk;
  // Ceiling well above the under one hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a; regWrData <= d; regWrStb <= 1'b1; regRdStb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a; regRdStb <= 1'b1; regWrStb <= 1'b0;
    @(posedge ref_clk);
    #1 chk(regRdData, exp);
  endtask
  task automatic idle(input int n);
    regWrStb <= 1'b0; regRdStb <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(8'ha3, 8'h00);
    rd(8'he0, 8'h04);
    foreach (zr[i]) rd(zr[i], 8'h00);
    wr(8'he1, 8'hff); wr(8'he0, 8'hff); wr(8'he3, 8'h5a); idle(1);
    chk(port1PullEn, 8'h7f);
    chk(port0PullEn, 8'h0b);
    chk(port3PullEn, 8'h5a);
    rd(8'he0, 8'h04);
    rd(8'he1, 8'h00);
    wr(8'hc3, 8'hf0); wr(8'hd3, 8'h3c); idle(1);
    chk(port3PinOe, 8'hf0);
    chk(port3PinOut, 8'h3c);
    chk(port3PullEn, 8'h0a);
    rd(8'hd3, 8'h30);
    port1PinIn <= 8'h2a;
    wr(8'hc1, 8'h7f); wr(8'hd1, 8'hd5); idle(1);
    chk(port1PinOe, 8'h7f);
    chk(port1PinOut, 8'h55);
    chk(port1PullEn, 8'h00);
    rd(8'hd1, 8'h55);
    wr(8'hc1, 8'h0f);
    rd(8'hd1, 8'h25);
    // Bit 2 written high while its pin is low must still read the pin
    wr(8'hb8, 8'hff); wr(8'hd0, 8'hff); idle(2);
    chk(port0PinOe, 8'h0b);
    chk(port0PinOut, 8'h0b);
    rd(8'hd0, 8'h0b);
    port0PinIn <= 8'h04; idle(3);
    rd(8'hd0, 8'h0f);
    wr(8'he5, 8'h10); wr(8'hc5, 8'h00);
    port5PinIn <= 8'h0d; convOutput <= 1'b1;
    wr(8'ha3, 8'h87); idle(3);
    chk({4'h0, convFeedbackClk, convChannelIn}, 8'h0d);
    chk({5'h0, convChannelSel, convInputEnable}, 8'h07);
    chk(port5PinOe, 8'h20);
    chk(port5PinOut & 8'h20, 8'h20);
    rd(8'hd5, 8'h00);
    rd(8'ha3, 8'h87);
    wr(8'ha3, 8'h7e);
    rd(8'ha3, 8'h06);
    wr(8'he5, 8'h3f); idle(1);
    chk({5'h0, convChannelIn}, 8'h00);
    chk(port5PullEn, 8'h3f);
    chk(port5PinOut & 8'h20, 8'h00);
    final_report;
  end
endmodule // testbench

// ==== include/gpcv_map.vh ====
// Purpose: Register map and field constants for the port and converter-sharing block.
// Assumes: 8-bit register port, byte offsets as printed.
// Notes: Definitions only.
`ifndef GPCV_MAP_VH
`define GPCV_MAP_VH
`define GPCV_ADDR_CONV_CTRL 8'ha3
`define GPCV_ADDR_P0_DATA 8'hd0
`define GPCV_ADDR_P1_DATA 8'hd1
`define GPCV_ADDR_P3_DATA 8'hd3
`define GPCV_ADDR_P5_DATA 8'hd5
`define GPCV_ADDR_P0_DIR 8'hb8
`define GPCV_ADDR_P1_DIR 8'hc1
`define GPCV_ADDR_P3_DIR 8'hc3
`define GPCV_ADDR_P5_DIR 8'hc5
`define GPCV_ADDR_P0_PULL 8'he0
`define GPCV_ADDR_P1_PULL 8'he1
`define GPCV_ADDR_P3_PULL 8'he3
`define GPCV_ADDR_P5_PULL 8'he5
`define GPCV_MASK_P0 8'h0f
`define GPCV_MASK_P0_OUT 8'h0b
`define GPCV_MASK_P1 8'h7f
`define GPCV_MASK_P3 8'hff
`define GPCV_MASK_P5 8'h3f
`define GPCV_MASK_CONV 8'h87
`define GPCV_MASK_CONV_IN 8'h0f
`define GPCV_MASK_CONV_OUT 8'h20
`define GPCV_BIT_CONV_EN 0
`define GPCV_BIT_CONV_OUT 7
`define GPCV_BIT_P0_INONLY 2
`define GPCV_BIT_P5_OUT 5
`define GPCV_RESET_VAL 8'h00
`endif

// ==== rtl/gpcv_port_share.v ====
// Purpose: Port 0/1/3/5 data, direction and pull-up logic with converter pin sharing on port 5.
// Assumes: Register port on ref_clk; pins come from outside and are synchronised.
// Notes: Pull-up registers are write-only; direction registers are included so pins can be driven.
// Functional notes
// - Writing one to a pull-up bit enables that pin's pull-up while its direction bit is zero; write-only, reset zero.
// - Port 0 bit 2 is input only, no pull-up; its pull-up bit reads one.
// - Port 0 bit 2 data reads one with external reset option; always read-only.
// - Port 5 bits 0..2 feed converter channel inputs while converter mode is on.
// - Port 5 bit 3 feeds converter feedback clock while converter mode is on.
// - Converter enable switches port 5 bits 0..3 from digital I/O to converter input.
// - Converter output enable makes port 5 bit 5 the converter output pin.
// - Converter control resets output enable, channel selects, enable to zero; bits 6..3 absent.
// - Direction zero makes a pin input; one drives it from the data register.
//
// Chosen here: the address-and-strobe port.
`include "gpcv_map.vh"
`timescale 1ns/1ps
module gpcv_port_share #(
  parameter EXT_RESET_OPTION = 1'b0
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [7:0] regRdData,
  // Port pins
  input wire [7:0] port0PinIn,
  output wire [7:0] port0PinOut,
  output wire [7:0] port0PinOe,
  output wire [7:0] port0PullEn,
  input wire [7:0] port1PinIn,
  output wire [7:0] port1PinOut,
  output wire [7:0] port1PinOe,
  output wire [7:0] port1PullEn,
  input wire [7:0] port3PinIn,
  output wire [7:0] port3PinOut,
  output wire [7:0] port3PinOe,
  output wire [7:0] port3PullEn,
  input wire [7:0] port5PinIn,
  output wire [7:0] port5PinOut,
  output wire [7:0] port5PinOe,
  output wire [7:0] port5PullEn,
  // Converter side
  output wire [2:0] convChannelIn,
  output wire convFeedbackClk,
  input wire convOutput,
  output wire convInputEnable,
  output wire [1:0] convChannelSel
);

  reg [7:0] p0Data_r, p1Data_r, p3Data_r, p5Data_r;
  reg [7:0] p0Dir_r, p1Dir_r, p3Dir_r, p5Dir_r;
  reg [7:0] p0Pull_r, p1Pull_r, p3Pull_r, p5Pull_r;
  reg [7:0] convCtrl_r;
  reg [7:0] p0Meta_r, p1Meta_r, p3Meta_r, p5Meta_r;
  reg [7:0] p0Sync_r, p1Sync_r, p3Sync_r, p5Sync_r;
  reg [7:0] rdNxt;

  wire convEn = convCtrl_r[`GPCV_BIT_CONV_EN];
  wire convOutEn = convCtrl_r[`GPCV_BIT_CONV_OUT];

  // Two-stage synchronisers; only the second stage is read
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p0Meta_r <= `GPCV_RESET_VAL;
      p1Meta_r <= `GPCV_RESET_VAL;
      p3Meta_r <= `GPCV_RESET_VAL;
      p5Meta_r <= `GPCV_RESET_VAL;
      p0Sync_r <= `GPCV_RESET_VAL;
      p1Sync_r <= `GPCV_RESET_VAL;
      p3Sync_r <= `GPCV_RESET_VAL;
      p5Sync_r <= `GPCV_RESET_VAL;
    end else begin
      p0Meta_r <= port0PinIn;
      p1Meta_r <= port1PinIn;
      p3Meta_r <= port3PinIn;
      p5Meta_r <= port5PinIn;
      p0Sync_r <= p0Meta_r;
      p1Sync_r <= p1Meta_r;
      p3Sync_r <= p3Meta_r;
      p5Sync_r <= p5Meta_r;
    end
  end

  // Register writes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p0Data_r <= `GPCV_RESET_VAL;
      p1Data_r <= `GPCV_RESET_VAL;
      p3Data_r <= `GPCV_RESET_VAL;
      p5Data_r <= `GPCV_RESET_VAL;
      p0Dir_r <= `GPCV_RESET_VAL;
      p1Dir_r <= `GPCV_RESET_VAL;
      p3Dir_r <= `GPCV_RESET_VAL;
      p5Dir_r <= `GPCV_RESET_VAL;
      p0Pull_r <= `GPCV_RESET_VAL;
      p1Pull_r <= `GPCV_RESET_VAL;
      p3Pull_r <= `GPCV_RESET_VAL;
      p5Pull_r <= `GPCV_RESET_VAL;
      convCtrl_r <= `GPCV_RESET_VAL;
    end else if (regWrStb) begin
      case (regAddr)
        // Bit 2 of port 0 is not storable: read-only data, no pull-up
        `GPCV_ADDR_P0_DATA: p0Data_r <= regWrData & `GPCV_MASK_P0_OUT;
        `GPCV_ADDR_P1_DATA: p1Data_r <= regWrData & `GPCV_MASK_P1;
        `GPCV_ADDR_P3_DATA: p3Data_r <= regWrData & `GPCV_MASK_P3;
        `GPCV_ADDR_P5_DATA: p5Data_r <= regWrData & `GPCV_MASK_P5;
        `GPCV_ADDR_P0_DIR: p0Dir_r <= regWrData & `GPCV_MASK_P0_OUT;
        `GPCV_ADDR_P1_DIR: p1Dir_r <= regWrData & `GPCV_MASK_P1;
        `GPCV_ADDR_P3_DIR: p3Dir_r <= regWrData & `GPCV_MASK_P3;
        `GPCV_ADDR_P5_DIR: p5Dir_r <= regWrData & `GPCV_MASK_P5;
        `GPCV_ADDR_P0_PULL: p0Pull_r <= regWrData & `GPCV_MASK_P0_OUT;
        `GPCV_ADDR_P1_PULL: p1Pull_r <= regWrData & `GPCV_MASK_P1;
        `GPCV_ADDR_P3_PULL: p3Pull_r <= regWrData & `GPCV_MASK_P3;
        `GPCV_ADDR_P5_PULL: p5Pull_r <= regWrData & `GPCV_MASK_P5;
        `GPCV_ADDR_CONV_CTRL: convCtrl_r <= regWrData & `GPCV_MASK_CONV;
        default: ;
      endcase
    end
  end

  // Pins taken by the converter lose digital drive and pull-up
  wire [7:0] p5Taken = (convEn ? `GPCV_MASK_CONV_IN : 8'h00);

  // Input-mode bits read the pin, output-mode bits read the latch; port 5 bits taken by the converter read zero
  wire [7:0] p0Read = ((p0Dir_r & p0Data_r) | (~p0Dir_r & p0Sync_r)) & `GPCV_MASK_P0_OUT;
  wire p02Read = EXT_RESET_OPTION ? 1'b1 : p0Sync_r[`GPCV_BIT_P0_INONLY];
  wire [7:0] p5Read = ((p5Dir_r & p5Data_r & ~p5Taken) | (~(p5Dir_r & ~p5Taken) & p5Sync_r)) &
                      `GPCV_MASK_P5 & ~p5Taken;

  always @* begin
    rdNxt = 8'h00;
    case (regAddr)
      `GPCV_ADDR_P0_DATA: rdNxt = p0Read | {5'h00, p02Read, 2'h0};
      `GPCV_ADDR_P1_DATA: rdNxt = ((p1Dir_r & p1Data_r) | (~p1Dir_r & p1Sync_r)) & `GPCV_MASK_P1;
      `GPCV_ADDR_P3_DATA: rdNxt = (p3Dir_r & p3Data_r) | (~p3Dir_r & p3Sync_r);
      `GPCV_ADDR_P5_DATA: rdNxt = p5Read;
      `GPCV_ADDR_P0_DIR: rdNxt = p0Dir_r;
      `GPCV_ADDR_P1_DIR: rdNxt = p1Dir_r;
      `GPCV_ADDR_P3_DIR: rdNxt = p3Dir_r;
      `GPCV_ADDR_P5_DIR: rdNxt = p5Dir_r;
      // Only the fixed bit of the port 0 pull-up register is visible
      `GPCV_ADDR_P0_PULL: rdNxt = 8'h04;
      `GPCV_ADDR_CONV_CTRL: rdNxt = convCtrl_r;
      default: rdNxt = 8'h00;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= `GPCV_RESET_VAL;
    end else if (regRdStb) begin
      regRdData <= rdNxt;
    end else begin
      regRdData <= `GPCV_RESET_VAL;
    end
  end

  // Pin drive
  assign port0PinOut = p0Data_r;
  assign port0PinOe = p0Dir_r;
  assign port0PullEn = p0Pull_r & ~p0Dir_r;
  assign port1PinOut = p1Data_r;
  assign port1PinOe = p1Dir_r;
  assign port1PullEn = p1Pull_r & ~p1Dir_r;
  assign port3PinOut = p3Data_r;
  assign port3PinOe = p3Dir_r;
  assign port3PullEn = p3Pull_r & ~p3Dir_r;
  // Converter output overrides port 5 bit 5 data and direction
  assign port5PinOut = convOutEn ? ((p5Data_r & ~`GPCV_MASK_CONV_OUT) | {2'h0, convOutput, 5'h00})
                                 : p5Data_r;
  assign port5PinOe = convOutEn ? ((p5Dir_r & ~p5Taken) | `GPCV_MASK_CONV_OUT)
                                : (p5Dir_r & ~p5Taken);
  // Pull-ups are forced off on shared pins as a guard, even though software should clear them
  assign port5PullEn = p5Pull_r & ~p5Dir_r & ~p5Taken &
                       ~(convOutEn ? `GPCV_MASK_CONV_OUT : 8'h00);

  assign convInputEnable = convEn;
  assign convChannelIn = convEn ? p5Sync_r[2:0] : 3'h0;
  assign convFeedbackClk = convEn ? p5Sync_r[3] : 1'b0;
  assign convChannelSel = convCtrl_r[2:1];

endmodule // gpcv_port_share
